//--- pkg/ltc_pkg.sv
/*
  ltc_pkg: constants shared by the logic timer cell design.
  Assumes a single 200 MHz system clock and an active-low asynchronous reset.

// Overview of operation
// [RULE1] Code 10 passes the single input straight to the output.
// [RULE2] On-delay: output rises only after a full period of steady high input.
// [RULE3] On-delay: falling input drops output at once and abandons timing.
// [RULE4] Off-delay: rising input raises output at once.
// [RULE5] Off-delay: falling input starts timer; output drops when period ends.
// [RULE6] One-shot: rising input gives one high pulse of the set period.
// [RULE7] Retriggerable: rising input during a pulse restarts a full pulse.
// [RULE8] Pulse train: while input high, alternate high and low set-period intervals.
// [RULE9] Codes 20 to 25 AND two inputs, result feeds the timer stage.
// [RULE10] Codes 30 to 35 OR two inputs, result feeds the timer stage.
// [RULE11] Codes 20 and 30 present the gate result with no timer.
// [RULE12] Units digit 0 to 5 picks the timer behaviour.
// [RULE13] One-shot ignores rising inputs during a pulse; original expiry kept.
*/
package ltc_pkg;

  localparam int LTC_CODE_W = 7;
  localparam int LTC_TIME_W = 16;
  // tens digit of the selection code picks the input stage
  localparam logic [3:0] LTC_TENS_PASS = 4'h1;
  localparam logic [3:0] LTC_TENS_AND = 4'h2;
  localparam logic [3:0] LTC_TENS_OR = 4'h3;
  localparam logic [6:0] LTC_CODE_MIN = 7'h0a;
  localparam logic [6:0] LTC_CODE_MAX = 7'h23;
  localparam logic [6:0] LTC_TEN = 7'h0a;
  localparam logic [3:0] LTC_UNITS_MAX = 4'h5;

  typedef enum logic [2:0] {
    LTC_MODE_PASS = 3'b000,
    LTC_MODE_ON_DELAY = 3'b001,
    LTC_MODE_OFF_DELAY = 3'b010,
    LTC_MODE_SINGLE = 3'b011,
    LTC_MODE_REARM = 3'b100,
    LTC_MODE_TRAIN = 3'b101
  } ltc_mode_e;

  typedef enum logic [1:0] {
    LTC_STAGE_PASS = 2'b00,
    LTC_STAGE_AND = 2'b01,
    LTC_STAGE_OR = 2'b10,
    LTC_STAGE_OFF = 2'b11
  } ltc_stage_e;

  // reset values
  localparam logic [LTC_TIME_W-1:0] LTC_COUNT_RST = 16'h0000;
  localparam logic LTC_OUT_RST = 1'b0;
  localparam logic [1:0] LTC_SYNC_RST = 2'b00;

endpackage

//--- logic/ltc_code_decode.sv
/*
  ltc_code_decode: splits the selection code into input stage and timer mode.
  Assumes the code is a static configuration value on the system clock.
*/
`timescale 1ns/100ps
module ltc_code_decode
  import ltc_pkg::*;
(
  input wire logic [LTC_CODE_W-1:0] code_in,
  output ltc_stage_e stage_out,
  output ltc_mode_e mode_out
);
  logic [3:0] tens;
  logic [3:0] units;
  logic [LTC_CODE_W-1:0] rest;

  always_comb begin
    tens = 4'h0;
    rest = code_in;
    for (int i = 0; i < 4; i++) begin
      if (rest >= LTC_TEN) begin
        rest = LTC_CODE_W'(rest - LTC_TEN);
        tens = 4'(tens + 4'h1);
      end
    end
    units = rest[3:0];
  end

  // [RULE12] units digit mode
  always_comb begin
    mode_out = LTC_MODE_PASS;
    case (units)
      4'h1: mode_out = LTC_MODE_ON_DELAY;
      4'h2: mode_out = LTC_MODE_OFF_DELAY;
      4'h3: mode_out = LTC_MODE_SINGLE;
      4'h4: mode_out = LTC_MODE_REARM;
      4'h5: mode_out = LTC_MODE_TRAIN;
      default: mode_out = LTC_MODE_PASS;
    endcase
  end

  // [RULE9] [RULE10] tens digit gate
  always_comb begin
    stage_out = LTC_STAGE_OFF;
    if (code_in >= LTC_CODE_MIN && code_in <= LTC_CODE_MAX && units <= LTC_UNITS_MAX) begin
      case (tens)
        LTC_TENS_PASS: stage_out = LTC_STAGE_PASS;
        LTC_TENS_AND: stage_out = LTC_STAGE_AND;
        LTC_TENS_OR: stage_out = LTC_STAGE_OR;
        default: stage_out = LTC_STAGE_OFF;
      endcase
    end
  end
endmodule

//--- logic/ltc_sync2.sv
/*
  ltc_sync2: two-flop synchroniser for one asynchronous level.
  Assumes the caller reads only sync_out.
*/
`timescale 1ns/100ps
module ltc_sync2
  import ltc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta <= LTC_SYNC_RST[0];
      sync_out <= LTC_SYNC_RST[1];
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

//--- logic/ltc_cell.sv
/*
  ltc_cell: configurable logic cell, input gate followed by a timer stage.
  Assumes terminal inputs are asynchronous to clk_sys_in; code and period are
  static configuration held by the surrounding logic. Period counts clocks.
*/
`timescale 1ns/100ps
module ltc_cell
  import ltc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic sig_a_in,
  input wire logic sig_b_in,
  input wire logic [LTC_CODE_W-1:0] code_in,
  input wire logic [LTC_TIME_W-1:0] period_in,
  output logic cell_out
);
  logic rst_meta;
  logic rst_n;
  logic a_s;
  logic b_s;
  logic gate;
  logic gate_q;
  logic rise;
  logic fall;
  logic [LTC_TIME_W-1:0] count;
  logic active;
  logic phase_high;
  logic next_out;
  logic expired;
  ltc_stage_e stage;
  ltc_mode_e mode;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ltc_sync2 u_sync_a (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(rst_n),
    .async_in(sig_a_in),
    .sync_out(a_s)
  );

  ltc_sync2 u_sync_b (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(rst_n),
    .async_in(sig_b_in),
    .sync_out(b_s)
  );

  ltc_code_decode u_decode (
    .code_in(code_in),
    .stage_out(stage),
    .mode_out(mode)
  );

  // [RULE9] [RULE10] input stage
  always_comb begin
    case (stage)
      LTC_STAGE_PASS: gate = a_s;
      LTC_STAGE_AND: gate = a_s & b_s;
      LTC_STAGE_OR: gate = a_s | b_s;
      default: gate = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate;
    end
  end

  assign rise = gate & ~gate_q;
  assign fall = ~gate & gate_q;
  // a zero period behaves as one clock so no mode can stall
  assign expired = (count <= 16'h0001);

  // timer counter and state; one process keeps a single driver per flop
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      count <= LTC_COUNT_RST;
      active <= 1'b0;
      phase_high <= 1'b0;
    end else begin
      case (mode)
        LTC_MODE_ON_DELAY: begin
          // [RULE2] start on rise
          if (rise) begin
            count <= period_in;
            active <= 1'b1;
          // [RULE3] abandon on fall
          end else if (!gate) begin
            active <= 1'b0;
            count <= LTC_COUNT_RST;
          end else if (active && !expired) begin
            count <= count - 16'h0001;
          end else if (active) begin
            active <= 1'b0;
            phase_high <= 1'b1;
          end
          if (!gate) begin
            phase_high <= 1'b0;
          end
        end
        LTC_MODE_OFF_DELAY: begin
          // [RULE5] start on fall
          if (gate) begin
            active <= 1'b0;
            phase_high <= 1'b1;
          end else if (fall) begin
            count <= period_in;
            active <= 1'b1;
          end else if (active && !expired) begin
            count <= count - 16'h0001;
          end else if (active) begin
            active <= 1'b0;
            phase_high <= 1'b0;
          end
        end
        LTC_MODE_SINGLE, LTC_MODE_REARM: begin
          // [RULE6] [RULE7] [RULE13] pulse start and restart
          if (rise && (!active || mode == LTC_MODE_REARM)) begin
            count <= period_in;
            active <= 1'b1;
            phase_high <= 1'b1;
          end else if (active && !expired) begin
            count <= count - 16'h0001;
          end else if (active) begin
            active <= 1'b0;
            phase_high <= 1'b0;
          end
        end
        LTC_MODE_TRAIN: begin
          // [RULE8] alternate intervals
          if (!gate) begin
            active <= 1'b0;
            phase_high <= 1'b0;
          end else if (rise || !active) begin
            count <= period_in;
            active <= 1'b1;
            phase_high <= 1'b1;
          end else if (!expired) begin
            count <= count - 16'h0001;
          end else begin
            count <= period_in;
            phase_high <= ~phase_high;
          end
        end
        default: begin
          active <= 1'b0;
          phase_high <= 1'b0;
          count <= LTC_COUNT_RST;
        end
      endcase
    end
  end

  // [RULE4] immediate high in off-delay
  always_comb begin
    case (mode)
      // [RULE1] [RULE11] no timer stage
      LTC_MODE_PASS: next_out = gate;
      LTC_MODE_OFF_DELAY: next_out = gate | phase_high;
      // [RULE3] low at once
      LTC_MODE_ON_DELAY: next_out = gate & phase_high;
      default: next_out = phase_high;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      cell_out <= LTC_OUT_RST;
    end else begin
      cell_out <= next_out;
    end
  end
endmodule

//--- tb/ltc_term_model.sv
/* ltc_term_model: terminal side of the cell, the two input contacts.
   assumes the bench sets the wanted levels just after a falling edge. */
`timescale 1ns/100ps
module ltc_term_model (
  input wire logic want_a_in,
  input wire logic want_b_in,
  output logic sig_a_out,
  output logic sig_b_out
);
  assign sig_a_out = want_a_in;
  assign sig_b_out = want_b_in;
endmodule

//--- tb/ltc_cell_properties.sv
/* ltc_cell_properties: timing checks on the cell ports.
   assumes code_in and period_in stay static while a mode runs. */
`timescale 1ns/100ps
module ltc_cell_properties
  import ltc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic sig_a_in,
  input wire logic sig_b_in,
  input wire logic [LTC_CODE_W-1:0] code_in,
  input wire logic [LTC_TIME_W-1:0] period_in,
  input wire logic cell_out
);
  logic g;
  logic [3:0] u;
  logic [15:0] g_hi, g_lo, o_hi;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  assign g = code_in < 7'h14 ? sig_a_in :
             code_in < 7'h1e ? sig_a_in & sig_b_in : sig_a_in | sig_b_in;
  assign u = 4'(code_in % 7'h0a);
  // run lengths, so timed edges can be judged without long repetitions
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      g_hi <= 16'h0000;
      g_lo <= 16'h0000;
      o_hi <= 16'h0000;
    end else begin
      g_hi <= g ? g_hi + 16'h0001 : 16'h0000;
      g_lo <= g ? 16'h0000 : g_lo + 16'h0001;
      o_hi <= cell_out ? o_hi + 16'h0001 : 16'h0000;
    end
  end
  a_pass_gate: assert property (
    u == 4'h0 && code_in == $past(code_in, 3) |-> cell_out == $past(g, 3))
    else $error("pass output differs from gate");
  a_ondly_rise: assert property (
    u == 4'h1 && $rose(cell_out) |-> g_hi >= period_in + 2 && g_hi <= period_in + 4)
    else $error("on-delay rose at wrong time");
  a_ondly_fall: assert property (u == 4'h1 && !$past(g, 3) |-> !cell_out)
    else $error("on-delay output not low");
  a_offdly_rise: assert property (u == 4'h2 && $past(g, 3) |-> cell_out)
    else $error("off-delay output not high");
  a_offdly_fall: assert property (
    u == 4'h2 && $fell(cell_out) |-> g_lo >= period_in + 2 && g_lo <= period_in + 4)
    else $error("off-delay fell at wrong time");
  a_shot_len: assert property (u == 4'h3 && $fell(cell_out) |-> o_hi == period_in)
    else $error("one-shot length wrong");
  a_rearm_len: assert property (u == 4'h4 && $fell(cell_out) |-> o_hi >= period_in)
    else $error("rearmed pulse too short");
  a_train_high: assert property (
    u == 4'h5 && $fell(cell_out) && $past(g, 3) |-> o_hi == period_in)
    else $error("train high interval wrong");
  c_shot: cover property (u == 4'h3 && $fell(cell_out));
  c_rearm: cover property (u == 4'h4 && $fell(cell_out));
  c_train: cover property (u == 4'h5 && $fell(cell_out));
endmodule
bind ltc_cell ltc_cell_properties chk_u (
  .clk_sys_in(clk_sys_in),
  .reset_n_in(reset_n_in),
  .sig_a_in(sig_a_in),
  .sig_b_in(sig_b_in),
  .code_in(code_in),
  .period_in(period_in),
  .cell_out(cell_out)
);

//--- tb/ltc_cell_tb_top.sv
/* ltc_cell_tb_top: directed scenarios for the logic timer cell.
   inputs change at the falling edge; period counts raw clocks. */
`timescale 1ns/100ps
module ltc_cell_tb_top
  import ltc_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic want_a = 1'b0;
  logic want_b = 1'b0;
  logic sig_a, sig_b, cell_out;
  logic [LTC_CODE_W-1:0] code = 7'h0a;
  logic [LTC_TIME_W-1:0] period = 16'h0004;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  always #2.5 clk_sys_in = ~clk_sys_in;
  ltc_term_model term_u (.want_a_in(want_a), .want_b_in(want_b), .sig_a_out(sig_a),
    .sig_b_out(sig_b));
  ltc_cell dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .sig_a_in(sig_a),
    .sig_b_in(sig_b), .code_in(code), .period_in(period), .cell_out(cell_out));
  task automatic err(input string m);
    num_errors++;
    $display("ERROR at %0t: %s", $time, m);
  endtask
  task automatic want_out(input logic e, input string m);
    total_checks++;
    if (cell_out !== e) err(m);
  endtask
  task automatic want_len(input int e, input string m);
    total_checks++;
    if (n != e) err(m);
  endtask
  task automatic ticks(input int k);
    repeat (k) @(negedge clk_sys_in);
  endtask
  task automatic runlen(input logic lvl);
    n = 0;
    while (cell_out === lvl && n < 60) begin
      n++;
      ticks(1);
    end
  endtask
  // idle long enough for any timer to drain before the code changes
  task automatic setup(input logic [6:0] c, input logic [15:0] p);
    want_a = 1'b0;
    want_b = 1'b0;
    ticks(12);
    code = c;
    period = p;
  endtask
  task automatic t_pass();
    logic [6:0] cs [3] = '{7'h0a, 7'h14, 7'h1e};
    logic e;
    for (int i = 0; i < 3; i++) begin
      for (int ab = 0; ab < 4; ab++) begin
        code = cs[i];
        want_a = ab[0];
        want_b = ab[1];
        ticks(4);
        e = i == 0 ? want_a : i == 1 ? want_a & want_b : want_a | want_b;
        want_out(e, "gate output wrong");
      end
    end
    $display("test pass done");
  endtask
  task automatic t_ondly();
    setup(7'h15, 16'h0006);
    want_a = 1'b1;
    want_b = 1'b1;
    ticks(6);
    want_out(1'b0, "on-delay too early");
    want_a = 1'b0;
    ticks(1);
    want_a = 1'b1;
    ticks(7);
    want_out(1'b0, "timing not abandoned");
    ticks(4);
    want_out(1'b1, "on-delay never rose");
    want_a = 1'b0;
    ticks(4);
    want_out(1'b0, "on-delay fall late");
    $display("test on-delay done");
  endtask
  task automatic t_offdly();
    setup(7'h20, 16'h0006);
    want_b = 1'b1;
    ticks(4);
    want_out(1'b1, "off-delay rise late");
    want_b = 1'b0;
    ticks(7);
    want_out(1'b1, "off-delay fell early");
    ticks(4);
    want_out(1'b0, "off-delay never fell");
    $display("test off-delay done");
  endtask
  // second rise comes three cycles after the first, inside the pulse
  task automatic t_shot(input logic [6:0] c, input int e);
    setup(c, 16'h0004);
    want_a = 1'b1;
    ticks(2);
    want_a = 1'b0;
    ticks(1);
    want_a = 1'b1;
    runlen(1'b0);
    runlen(1'b1);
    want_len(e, "pulse length wrong");
    $display("test pulse done");
  endtask
  task automatic t_train();
    setup(7'h0f, 16'h0003);
    want_a = 1'b1;
    runlen(1'b0);
    runlen(1'b1);
    want_len(3, "train high wrong");
    runlen(1'b0);
    want_len(3, "train low wrong");
    runlen(1'b1);
    want_a = 1'b0;
    ticks(5);
    want_out(1'b0, "train kept running");
    $display("test train done");
  endtask
  // codes outside the decoded set must hold the output low
  task automatic t_bad();
    setup(7'h10, 16'h0004);
    want_a = 1'b1;
    want_b = 1'b1;
    ticks(6);
    want_out(1'b0, "invalid code drove output");
    code = 7'h13;
    ticks(6);
    want_out(1'b0, "invalid code drove output");
    $display("test invalid code done");
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    ticks(3);
    t_pass();
    t_ondly();
    t_offdly();
    t_shot(7'h0d, 4);
    t_shot(7'h0e, 7);
    t_train();
    t_bad();
    give_verdict();
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 2000) begin
      err("timeout");
      give_verdict();
    end
  end
endmodule
